/* logic/sac_adc_ctrl.sv */
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
// How it works
// - Conversions start by software, timer 0/1/2 overflow or external start.
// - Completion sets done flag; its interrupt fires only when enabled.
// - Each completed conversion latches the 8-bit result for software.
// - Result compared with window limits; interrupt on inside or outside.
// - Background conversions interrupt only on window hit, not every result.
// - Converter runs only when enable bit is 1, else low-power shutdown.
// - Gain field selects 0.5, 1, 2 or 4 for the input gain stage.
// - Input mux gives 11 selections, single-ended to ground or differential.
// - Temperature sensor sits on the highest positive mux selection.
// - Reference select 0 picks external reference, 1 picks the supply.
// - Bias enable reads 1 when converter, sensor or oscillator enabled.
// - Sensor enable switches sensor; disabled sensor gives meaningless data.
// - Back-to-back conversions take 21 cycles each (20 plus the idle cycle), about 476 ksps, not 500 ksps.
module sac_adc_ctrl
  import sac_pkg::*;
#(
  parameter int CONV_CYCLES = sac_pkg::CONV_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Start sources and oscillator enable
  input wire logic timer0Ovf,
  input wire logic timer1Ovf,
  input wire logic timer2Ovf,
  input wire logic extStart,
  input wire logic oscEnable,
  // Analog front end
  input wire logic cmpHigh,
  output logic [3:0] muxPos,
  output logic [3:0] muxNeg,
  output logic [1:0] gainSel,
  output logic adcPowerOn,
  output logic sampleHold,
  output logic [7:0] sarTrial,
  output logic refSelect,
  output logic biasOn,
  output logic tempOn,
  // Interrupt requests
  output logic doneIrq,
  output logic winIrq
);
  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OFF = 2'b00, ST_IDLE = 2'b01, ST_TRACK = 2'b10, ST_CONV = 2'b11
  } sac_state_t;

  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam int TRACK_CYC = CONV_CYCLES - RES_W - 1;

  sac_state_t state_r;
  logic enable_r;
  logic done_r;
  logic win_r;
  logic inside_r;
  logic [2:0] src_r;
  logic refSel_r;
  logic tempEn_r;
  logic biasSw_r;
  logic [3:0] muxPos_r;
  logic [3:0] muxNeg_r;
  logic [1:0] gain_r;
  logic [7:0] result_r;
  logic [7:0] winLo_r;
  logic [7:0] winHi_r;
  logic ienDone_r;
  logic ienWin_r;
  logic [7:0] sar_r;
  logic [7:0] bit_r;
  logic [CW-1:0] cnt_r;
  logic extSync;
  logic extPrev_r;
  logic swStart;
  logic trig;
  logic finish;
  logic [7:0] finalVal;
  logic winHit;

  // External start is a pin: settle it through three stages
  sac_sync uExtSync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .din(extStart),
    .dout(extSync)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extPrev_r <= 1'b0;
    end else if (ce) begin
      extPrev_r <= extSync;
    end
  end

  // ---------------------------------------------------------------
  // Start selection
  // ---------------------------------------------------------------
  assign swStart = regWr && (regAddr == ADDR_CTRL) && regWdata[CTL_BUSY];
  always_comb begin
    case (sac_src_t'(src_r))
      SRC_SW: trig = swStart;
      SRC_T0: trig = timer0Ovf;
      SRC_T1: trig = timer1Ovf;
      SRC_T2: trig = timer2Ovf;
      SRC_EXT: trig = extSync && !extPrev_r;
      default: trig = 1'b0;
    endcase
  end

  // Last SAR step: keep or drop the trial bit from the comparator
  assign finish = (state_r == ST_CONV) && bit_r[0];
  assign finalVal = cmpHigh ? sar_r : (sar_r & ~bit_r);
  // Window test on the value being latched, in the latching cycle
  assign winHit = inside_r ?
      ((finalVal >= winLo_r) && (finalVal <= winHi_r)) :
      ((finalVal < winLo_r) || (finalVal > winHi_r));

  // ---------------------------------------------------------------
  // Conversion sequencer: track, then one bit per cycle
  // ---------------------------------------------------------------
  // Trial code and hold move with the SAR state; a late copy would judge the previous trial
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_OFF;
      cnt_r <= '0;
      sar_r <= ZERO8;
      bit_r <= ZERO8;
      sampleHold <= 1'b0;
      sarTrial <= ZERO8;
    end else if (ce) begin
      case (state_r)
        ST_OFF: begin
          if (enable_r) begin
            state_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (!enable_r) begin
            state_r <= ST_OFF;
          end else if (trig) begin
            state_r <= ST_TRACK;
            cnt_r <= CW'(TRACK_CYC);
          end
        end
        ST_TRACK: begin
          if (!enable_r) begin
            state_r <= ST_OFF;
          end else if (cnt_r == '0) begin
            state_r <= ST_CONV;
            sar_r <= 8'h80;
            bit_r <= 8'h80;
            sampleHold <= 1'b1;
            sarTrial <= 8'h80;
          end else begin
            cnt_r <= cnt_r - CW'(1);
          end
        end
        ST_CONV: begin
          if (!enable_r) begin
            state_r <= ST_OFF;
            sampleHold <= 1'b0;
          end else if (bit_r[0]) begin
            state_r <= ST_IDLE;
            sampleHold <= 1'b0;
          end else begin
            sar_r <= finalVal | (bit_r >> 1);
            sarTrial <= finalVal | (bit_r >> 1);
            bit_r <= bit_r >> 1;
          end
        end
        default: state_r <= ST_OFF;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Result and status flags; hardware set wins over software clear
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_r <= ZERO8;
      done_r <= 1'b0;
      win_r <= 1'b0;
    end else if (ce) begin
      if (regWr && regAddr == ADDR_CTRL) begin
        done_r <= regWdata[CTL_DONE];
        win_r <= regWdata[CTL_WIN];
      end
      if (finish && enable_r) begin
        result_r <= finalVal;
        done_r <= 1'b1;
        if (winHit) begin
          win_r <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Software-written configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_r <= 1'b0;
      inside_r <= 1'b0;
      src_r <= 3'h0;
      refSel_r <= 1'b0;
      tempEn_r <= 1'b0;
      biasSw_r <= 1'b0;
      muxPos_r <= 4'h0;
      muxNeg_r <= MUX_GND;
      gain_r <= 2'h0;
      winLo_r <= ZERO8;
      winHi_r <= ZERO8;
      ienDone_r <= 1'b0;
      ienWin_r <= 1'b0;
    end else if (ce && regWr) begin
      case (regAddr)
        ADDR_CTRL: begin
          enable_r <= regWdata[CTL_EN];
          inside_r <= regWdata[CTL_INSIDE];
          src_r <= {regWdata[CTL_SRC_HI], regWdata[CTL_SRC_LO +: 2]};
        end
        ADDR_REF: begin
          refSel_r <= regWdata[REF_SEL];
          tempEn_r <= regWdata[REF_TEMP];
          biasSw_r <= regWdata[REF_BIAS];
        end
        ADDR_MUX: begin
          // Out-of-range selections are ignored to keep 11 choices
          if (regWdata[7:4] <= MUX_LAST) begin
            muxPos_r <= regWdata[7:4];
          end
          if (regWdata[3:0] <= MUX_LAST) begin
            muxNeg_r <= regWdata[3:0];
          end
        end
        ADDR_GAIN: gain_r <= regWdata[1:0];
        ADDR_WLO: winLo_r <= regWdata;
        ADDR_WHI: winHi_r <= regWdata;
        ADDR_IEN: begin
          ienDone_r <= regWdata[IEN_DONE];
          ienWin_r <= regWdata[IEN_WIN];
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read data, valid the cycle after the read strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata <= ZERO8;
    end else if (ce) begin
      regRdata <= ZERO8;
      if (regRd) begin
        case (regAddr)
          ADDR_CTRL: regRdata <= {enable_r, src_r[2], done_r,
                                  (state_r == ST_TRACK) || (state_r == ST_CONV),
                                  win_r, inside_r, src_r[1:0]};
          ADDR_REF: regRdata <= {4'h0, refSel_r, tempEn_r,
                                 biasSw_r | enable_r | tempEn_r | oscEnable,
                                 1'b0};
          ADDR_MUX: regRdata <= {muxPos_r, muxNeg_r};
          ADDR_GAIN: regRdata <= {6'h00, gain_r};
          ADDR_RES: regRdata <= result_r;
          ADDR_WLO: regRdata <= winLo_r;
          ADDR_WHI: regRdata <= winHi_r;
          ADDR_IEN: regRdata <= {6'h00, ienWin_r, ienDone_r};
          default: regRdata <= ZERO8;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs to the analog side and interrupt lines
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      muxPos <= 4'h0;
      muxNeg <= MUX_GND;
      gainSel <= 2'h0;
      adcPowerOn <= 1'b0;
      refSelect <= 1'b0;
      biasOn <= 1'b0;
      tempOn <= 1'b0;
      doneIrq <= 1'b0;
      winIrq <= 1'b0;
    end else if (ce) begin
      muxPos <= muxPos_r;
      muxNeg <= muxNeg_r;
      gainSel <= gain_r;
      adcPowerOn <= enable_r;
      refSelect <= refSel_r;
      biasOn <= biasSw_r | enable_r | tempEn_r | oscEnable;
      tempOn <= tempEn_r;
      // Background mode: leave done interrupt off, use window only
      doneIrq <= done_r & ienDone_r;
      winIrq <= win_r & ienWin_r;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_start;
    (state_r == ST_IDLE) && trig && enable_r && ce;
  endsequence

  a_start_track: assert property (@(posedge clk) disable iff (rst)
    s_start |=> state_r == ST_TRACK)
    else $error("trigger did not start tracking");
  a_done_set: assert property (@(posedge clk) disable iff (rst)
    finish && enable_r && ce |=> done_r)
    else $error("done flag not set");
  a_result_latch: assert property (@(posedge clk) disable iff (rst)
    finish && enable_r && ce |=> result_r == $past(finalVal))
    else $error("result not latched");
  a_win_set: assert property (@(posedge clk) disable iff (rst)
    finish && enable_r && ce && winHit |=> win_r && done_r)
    else $error("window flag inconsistent");
  a_irq_gate: assert property (@(posedge clk) disable iff (rst)
    ce && !ienDone_r |=> !doneIrq)
    else $error("done irq while disabled");
  a_win_irq: assert property (@(posedge clk) disable iff (rst)
    ce && win_r && ienWin_r |=> winIrq)
    else $error("window irq missing");
  a_shutdown_off: assert property (@(posedge clk) disable iff (rst)
    ce && !enable_r && state_r != ST_OFF |=> state_r == ST_OFF)
    else $error("no shutdown");
  a_conv_rate: assert property (@(posedge clk) disable iff (rst)
    s_start |-> ##[1:CONV_CYCLES] (finish || !ce || !enable_r))
    else $error("conversion too slow");
  a_bias_force: assert property (@(posedge clk) disable iff (rst)
    ce && (enable_r || tempEn_r) |=> biasOn)
    else $error("bias not forced");
  a_ref_sel: assert property (@(posedge clk) disable iff (rst)
    ce && regWr && regAddr == ADDR_REF ##1 ce |=> refSelect == $past(regWdata[REF_SEL], 2))
    else $error("reference select wrong");
  a_mux_range: assert property (@(posedge clk) disable iff (rst)
    muxPos_r <= MUX_LAST && muxNeg_r <= MUX_LAST)
    else $error("mux selection out of range");
  a_gain_out: assert property (@(posedge clk) disable iff (rst)
    ce && regWr && regAddr == ADDR_GAIN ##1 ce |=> gainSel == $past(regWdata[1:0], 2))
    else $error("gain not applied");
endmodule

/* logic/sac_pkg.sv */
package sac_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;  // converter_control_reg
  localparam logic [3:0] ADDR_REF = 4'h1;   // reference_control_reg
  localparam logic [3:0] ADDR_MUX = 4'h2;   // analog_input_mux selects
  localparam logic [3:0] ADDR_GAIN = 4'h3;  // input_gain_stage setting
  localparam logic [3:0] ADDR_RES = 4'h4;   // conversion result
  localparam logic [3:0] ADDR_WLO = 4'h5;   // window low limit
  localparam logic [3:0] ADDR_WHI = 4'h6;   // window high limit
  localparam logic [3:0] ADDR_IEN = 4'h7;   // interrupt enables

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTL_EN = 7;       // converter_enable_bit
  localparam int CTL_DONE = 5;     // completion flag
  localparam int CTL_BUSY = 4;     // write 1 = software start
  localparam int CTL_WIN = 3;      // window flag
  localparam int CTL_INSIDE = 2;   // 1: flag inside window, 0: outside
  localparam int CTL_SRC_LO = 0;   // start source, two bits (+ bit 6)
  localparam int CTL_SRC_HI = 6;
  localparam int REF_SEL = 3;      // reference_select
  localparam int REF_TEMP = 2;     // temp_sensor_enable
  localparam int REF_BIAS = 1;     // bias_generator_enable
  localparam int IEN_DONE = 0;
  localparam int IEN_WIN = 1;

  // ---------------------------------------------------------------
  // Start sources, conversion timing, mux
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_SW = 3'h0, SRC_T0 = 3'h1, SRC_T1 = 3'h2, SRC_T2 = 3'h3, SRC_EXT = 3'h4
  } sac_src_t;
  localparam int CLK_HZ = 10_000_000;
  localparam int MAX_SPS = 500_000;
  localparam int CONV_CYC = CLK_HZ / MAX_SPS;  // 20 cycles per conversion
  localparam int RES_W = 8;
  localparam logic [3:0] MUX_TEMP = 4'ha;      // highest positive selection
  localparam logic [3:0] MUX_LAST = 4'ha;      // 11 selections: 0..10
  localparam logic [3:0] MUX_GND = 4'ha;       // negative select for ground
  localparam logic [7:0] ZERO8 = 8'h00;
endpackage

/* logic/sac_sync.sv */
`timescale 1ns/1ns
// Three-stage synchroniser; output rises or falls once stages 2 and 3 agree
module sac_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Asynchronous level in, settled level out
  input wire logic din,
  output logic dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ---------------------------------------------------------------
  // Shift chain; s1_r is read only by s2_r
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Settled level only moves when the last two stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout <= 1'b0;
    end else if (ce && (s2_r == s3_r)) begin
      dout <= s3_r;
    end
  end
endmodule

/* dv/sac_front_model.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Analog front end: mux, gain stage and comparator
// ---------------------------------------------------------------
module sac_front_model
  import sac_pkg::*;
(
  // Clock
  input wire logic clk,
  // Front-end controls from the converter
  input wire logic [3:0] muxPos,
  input wire logic [1:0] gainSel,
  input wire logic tempOn,
  input wire logic sampleHold,
  input wire logic [7:0] sarTrial,
  // Comparator decision
  output logic cmpHigh
);
  logic [9:0] wide;
  logic [7:0] level;
  logic idleToggle = 1'b0;
  logic [7:0] noise = 8'h5a;

  // Each positive selection has its own level; gain scales and saturates
  always_comb begin
    wide = {2'b00, muxPos, 4'h3};
    case (gainSel)
      2'h0: wide = wide >> 1;
      2'h2: wide = wide << 1;
      2'h3: wide = wide << 2;
      default: wide = wide;
    endcase
    level = (wide > 10'h0ff) ? 8'hff : wide[7:0];
    // A switched-off sensor floats, so its reading wanders
    if (muxPos == MUX_TEMP && !tempOn) begin
      level = noise;
    end
  end

  // Outside a hold the comparator output is not trustworthy: keep it moving
  always @(posedge clk) begin
    idleToggle <= ~idleToggle;
    noise <= noise + 8'h3b;
  end

  assign cmpHigh = sampleHold ? (level >= sarTrial) : idleToggle;
endmodule

/* dv/tb_sar_adc_control_and_reference.sv */
`timescale 1ns/1ns
module tb_sar_adc_control_and_reference;
  import sac_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic timer0Ovf = 1'b0;
  logic timer1Ovf = 1'b0;
  logic timer2Ovf = 1'b0;
  logic extStart = 1'b0;
  logic oscEnable = 1'b0;
  logic [7:0] regRdata, sarTrial, rdv, ctl;
  logic [3:0] muxPos, muxNeg;
  logic [1:0] gainSel;
  logic cmpHigh, adcPowerOn, sampleHold, refSelect, biasOn, tempOn, doneIrq, winIrq;
  logic [2:0] src;
  int n_mismatch = 0;
  int n_compared = 0;
  int nCyc = 0;
  int n;
  // Selection 2 at gains 0.5, 1, 2, 4
  logic [7:0] expTab [4] = '{8'h11, 8'h23, 8'h46, 8'h8c};

  always #50 clk = ~clk;

  sac_adc_ctrl #(.CONV_CYCLES(CONV_CYC)) sac_adc_ctrl_i (.clk(clk), .rst(rst), .ce(ce),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .timer0Ovf(timer0Ovf), .timer1Ovf(timer1Ovf),
    .timer2Ovf(timer2Ovf), .extStart(extStart), .oscEnable(oscEnable),
    .cmpHigh(cmpHigh), .muxPos(muxPos), .muxNeg(muxNeg), .gainSel(gainSel),
    .adcPowerOn(adcPowerOn), .sampleHold(sampleHold), .sarTrial(sarTrial),
    .refSelect(refSelect), .biasOn(biasOn), .tempOn(tempOn), .doneIrq(doneIrq),
    .winIrq(winIrq));

  sac_front_model sac_front_model_i (.clk(clk), .muxPos(muxPos), .gainSel(gainSel),
    .tempOn(tempOn), .sampleHold(sampleHold), .sarTrial(sarTrial), .cmpHigh(cmpHigh));

  // ---------------------------------------------------------------
  // Bus, compare and closing tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #50;
    d = regRdata;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Bounded wait; the done interrupt must be enabled
  task automatic waitDone(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (doneIrq !== 1'b1 && cnt < 60);
  endtask

  task automatic trig(input logic [2:0] s);
    @(posedge clk);
    timer0Ovf <= (s == SRC_T0);
    timer1Ovf <= (s == SRC_T1);
    timer2Ovf <= (s == SRC_T2);
    extStart <= (s == SRC_EXT);
    @(posedge clk);
    timer0Ovf <= 1'b0;
    timer1Ovf <= 1'b0;
    timer2Ovf <= 1'b0;
  endtask

  // Background run: only the window interrupt is enabled
  task automatic winRun(input logic [7:0] c, input logic expWin, input logic [7:0] expCtl);
    wr(ADDR_CTRL, 8'h80);
    wr(ADDR_CTRL, c);
    repeat (22) @(posedge clk);
    #1;
    chk({7'h0, winIrq}, {7'h0, expWin});
    chk({7'h0, doneIrq}, 8'h00);
    rd(ADDR_CTRL, rdv);
    chk(rdv, expCtl);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A hung handshake must not stall the run forever
  always @(posedge clk) begin
    nCyc <= nCyc + 1;
    if (nCyc == 4000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, rdv);
    chk(rdv, 8'h00);
    rd(ADDR_MUX, rdv);
    chk(rdv, {4'h0, MUX_GND});
    rd(4'h8, rdv);
    chk(rdv, 8'h00);
    $display("test reset done");
    wr(ADDR_REF, 8'h08);
    settle();
    chk({7'h0, refSelect}, 8'h01);
    chk({7'h0, biasOn}, 8'h00);
    wr(ADDR_REF, 8'h04);
    settle();
    chk({7'h0, refSelect}, 8'h00);
    chk({7'h0, tempOn}, 8'h01);
    chk({7'h0, biasOn}, 8'h01);
    rd(ADDR_REF, rdv);
    chk(rdv, 8'h06);
    wr(ADDR_REF, 8'h00);
    oscEnable <= 1'b1;
    settle();
    chk({7'h0, biasOn}, 8'h01);
    oscEnable <= 1'b0;
    wr(ADDR_REF, 8'h02);
    settle();
    chk({7'h0, biasOn}, 8'h01);
    wr(ADDR_REF, 8'h00);
    settle();
    chk({7'h0, biasOn}, 8'h00);
    $display("test reference done");
    wr(ADDR_MUX, 8'hbc);
    rd(ADDR_MUX, rdv);
    chk(rdv, 8'h0a);
    wr(ADDR_MUX, 8'ha5);
    settle();
    chk({4'h0, muxPos}, {4'h0, MUX_TEMP});
    chk({4'h0, muxNeg}, 8'h05);
    wr(ADDR_MUX, 8'h2a);
    wr(ADDR_IEN, 8'h01);
    wr(ADDR_CTRL, 8'h10);
    repeat (25) @(posedge clk);
    #1;
    chk({7'h0, adcPowerOn}, 8'h00);
    chk({7'h0, doneIrq}, 8'h00);
    $display("test mux and shutdown done");
    // Every start source, gain from the low two source bits, so external start repeats gain 0.5
    for (int s = 0; s < 5; s++) begin
      src = 3'(s);
      ctl = 8'h80 | {1'b0, src[2], 4'h0, src[1:0]};
      wr(ADDR_GAIN, {6'h0, src[1:0]});
      wr(ADDR_CTRL, ctl);
      repeat (3) @(posedge clk);
      if (s == 0) begin
        wr(ADDR_CTRL, ctl | 8'h10);
      end else begin
        trig(src);
      end
      waitDone(n);
      if (s == 0) begin
        chk(8'(n), 8'(CONV_CYC + 1));
      end
      chk({7'h0, doneIrq}, 8'h01);
      chk({7'h0, adcPowerOn}, 8'h01);
      chk({6'h0, gainSel}, {6'h0, src[1:0]});
      rd(ADDR_RES, rdv);
      chk(rdv, expTab[src[1:0]]);
      extStart <= 1'b0;
      wr(ADDR_CTRL, ctl);
    end
    $display("test start sources done");
    wr(ADDR_IEN, 8'h02);
    wr(ADDR_WLO, 8'h20);
    wr(ADDR_WHI, 8'h30);
    wr(ADDR_GAIN, 8'h01);
    winRun(8'h94, 1'b1, 8'hac);
    winRun(8'h90, 1'b0, 8'ha0);
    wr(ADDR_WHI, 8'h22);
    winRun(8'h90, 1'b1, 8'ha8);
    $display("test window done");
    tally_and_finish();
  end
endmodule
